// file: rtl/cansr_status.sv
// CAN controller status and retry control with an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cansr_defines.svh"

module cansr_status (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire cansr_pkg::cansr_engine_t engine,
  input  wire cansr_pkg::cansr_obj_ev_t obj_ev,
  output logic                       auto_resend_enable,
  output logic                       status_irq
);

  // Status flags and error state.
  logic             transmit_done_flag, next_transmit_done_flag;
  logic             receive_done_flag, next_receive_done_flag;
  logic             bus_off_flag, next_bus_off_flag;
  logic             error_warning_flag, next_error_warning_flag;
  logic             error_passive_flag, next_error_passive_flag;
  logic [2:0]       last_error_code_field, next_last_error_code_field;
  logic             status_pending, next_status_pending;
  logic [1:0]       control, next_control;
  logic [31:0]      transmit_pending_flag, next_transmit_pending_flag;
  logic [31:0]      fresh_message_flag, next_fresh_message_flag;
  logic [31:0]      object_configured_flag, next_object_configured_flag;
  logic [31:0]      overwrite_lost_flag, next_overwrite_lost_flag;
  logic [15:0]      err_counts, next_err_counts;

  // Bus channel state.
  logic             aw_held, next_aw_held;
  logic             w_held, next_w_held;
  logic [11:0]      aw_addr, next_aw_addr;
  logic [31:0]      w_data, next_w_data;
  logic [3:0]       w_strb, next_w_strb;
  logic             bvalid, next_bvalid;
  logic [1:0]       bresp, next_bresp;
  logic             rvalid, next_rvalid;
  logic [1:0]       rresp, next_rresp;
  logic [31:0]      rdata, next_rdata;
  logic             aw_ready, next_aw_ready;
  logic             w_ready, next_w_ready;
  logic             ar_ready, next_ar_ready;
  logic             irq, next_irq;

  logic             do_write;
  logic             do_read;
  logic             status_read;
  logic [31:0]      status_word;
  logic [31:0]      wmask;

  // Bus handshakes: one write and one read in flight, address and data in any order.
  always_comb begin
    do_write = aw_held && w_held && !bvalid;
    do_read  = s_axi_arvalid && !rvalid;
    status_read = do_read && (s_axi_araddr == `CANSR_OFF_STATUS);
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    status_word = 32'h0000_0000;
    status_word[`CANSR_BIT_LEC_LSB +: 3] = last_error_code_field;
    status_word[`CANSR_BIT_TXOK]   = transmit_done_flag;
    status_word[`CANSR_BIT_RXOK]   = receive_done_flag;
    status_word[`CANSR_BIT_EPASS]  = error_passive_flag;
    status_word[`CANSR_BIT_EWARN]  = error_warning_flag;
    status_word[`CANSR_BIT_BUSOFF] = bus_off_flag;
    status_word[`CANSR_BIT_STS_INT] = status_pending;
  end

  // Next values of the bus channels.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      // Only the control register is writable; everything else answers SLVERR.
      next_bresp   = (aw_addr == `CANSR_OFF_CONTROL) ? 2'h0 : 2'h2;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      case (s_axi_araddr)
        `CANSR_OFF_STATUS:  next_rdata = status_word;
        `CANSR_OFF_TX_PEND: next_rdata = transmit_pending_flag;
        `CANSR_OFF_FRESH:   next_rdata = fresh_message_flag;
        `CANSR_OFF_VALID:   next_rdata = object_configured_flag;
        `CANSR_OFF_CONTROL: next_rdata = {30'h0000_0000, control};
        `CANSR_OFF_LOST:    next_rdata = overwrite_lost_flag;
        `CANSR_OFF_ERRCNT:  next_rdata = {16'h0000, err_counts};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'h2;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // Ready outputs are registered copies of the free state, so no output leaves through a gate.
    next_aw_ready = !next_aw_held;
    next_w_ready  = !next_w_held;
    next_ar_ready = !next_rvalid;
  end

  // Next values of the control register and the status flags.
  always_comb begin
    next_control = control;
    if (do_write && aw_addr == `CANSR_OFF_CONTROL) begin
      next_control = (control & ~wmask[1:0]) | (w_data[1:0] & wmask[1:0]);
    end
    next_err_counts = {engine.tx_err_count, engine.rx_err_count};
    next_bus_off_flag = engine.bus_off;
    // Warning once either counter reaches the limit.
    next_error_warning_flag = (engine.tx_err_count >= `CANSR_WARN_LIMIT) ||
                              (engine.rx_err_count >= `CANSR_WARN_LIMIT);
    next_error_passive_flag = !engine.bus_off &&
                              ((engine.tx_err_count >= `CANSR_PASSIVE_LIMIT) ||
                               (engine.rx_err_count >= `CANSR_PASSIVE_LIMIT));
    next_receive_done_flag  = receive_done_flag;
    next_transmit_done_flag = transmit_done_flag;
    next_last_error_code_field = last_error_code_field;
    next_status_pending = status_pending;
    // A status read clears the ok flags and the code; a new event in the same cycle wins.
    if (status_read) begin
      next_receive_done_flag  = 1'b0;
      next_transmit_done_flag = 1'b0;
      next_last_error_code_field = cansr_pkg::CANSR_LEC_NONE;
      next_status_pending = 1'b0;
    end
    if (engine.rx_ok) begin
      next_receive_done_flag = 1'b1;
    end
    if (engine.tx_ok) begin
      next_transmit_done_flag = 1'b1;
    end
    // The engine classifies stuff, form, ack, bit and checksum errors into fixed codes.
    if (engine.err_valid) begin
      next_last_error_code_field = engine.err_code;
    end
    if (engine.rx_ok || engine.tx_ok || engine.err_valid ||
        (engine.bus_off != bus_off_flag) || (next_error_warning_flag != error_warning_flag) ||
        (next_error_passive_flag != error_passive_flag)) begin
      next_status_pending = 1'b1;
    end
    next_irq = next_status_pending && control[`CANSR_BIT_STS_IEN];
  end

  // Next values of the per-object bitmaps; bit n-1 belongs to object n.
  always_comb begin
    // Set over clear: a request or store in the same cycle as its clear survives.
    next_transmit_pending_flag = (transmit_pending_flag & ~obj_ev.tx_done) | obj_ev.tx_request;
    // Retry off: any engine error drops every pending request except those raised in the same cycle.
    if (!control[`CANSR_BIT_RETRY] && engine.err_valid) begin
      next_transmit_pending_flag = obj_ev.tx_request;
    end
    next_fresh_message_flag = (fresh_message_flag & ~obj_ev.host_read) | obj_ev.rx_store;
    next_overwrite_lost_flag = (overwrite_lost_flag & ~obj_ev.host_read) |
                               (fresh_message_flag & obj_ev.rx_store);
    next_object_configured_flag = (object_configured_flag & ~obj_ev.cfg_clear) | obj_ev.cfg_set;
  end

  // Bus channel registers; the ready flops leave reset high so the first request is taken at once.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      aw_ready <= 1'b1;
      w_ready <= 1'b1;
      ar_ready <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      aw_ready <= next_aw_ready;
      w_ready <= next_w_ready;
      ar_ready <= next_ar_ready;
    end
  end

  // Control and status registers; the resend bit leaves reset on.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control <= `CANSR_RST_CONTROL;
      err_counts <= 16'h0000;
      bus_off_flag <= 1'b0;
      error_warning_flag <= 1'b0;
      error_passive_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      transmit_done_flag <= 1'b0;
      last_error_code_field <= 3'h0;
      status_pending <= 1'b0;
      irq <= 1'b0;
    end else begin
      control <= next_control;
      err_counts <= next_err_counts;
      bus_off_flag <= next_bus_off_flag;
      error_warning_flag <= next_error_warning_flag;
      error_passive_flag <= next_error_passive_flag;
      receive_done_flag <= next_receive_done_flag;
      transmit_done_flag <= next_transmit_done_flag;
      last_error_code_field <= next_last_error_code_field;
      status_pending <= next_status_pending;
      irq <= next_irq;
    end
  end

  // Per-object bitmap registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      transmit_pending_flag <= 32'h0000_0000;
      fresh_message_flag <= 32'h0000_0000;
      overwrite_lost_flag <= 32'h0000_0000;
      object_configured_flag <= 32'h0000_0000;
    end else begin
      transmit_pending_flag <= next_transmit_pending_flag;
      fresh_message_flag <= next_fresh_message_flag;
      overwrite_lost_flag <= next_overwrite_lost_flag;
      object_configured_flag <= next_object_configured_flag;
    end
  end

  // Outputs come straight from flip-flops.
  always_comb begin
    s_axi_awready = aw_ready;
    s_axi_wready  = w_ready;
    s_axi_bvalid  = bvalid;
    s_axi_bresp   = bresp;
    s_axi_arready = ar_ready;
    s_axi_rvalid  = rvalid;
    s_axi_rresp   = rresp;
    s_axi_rdata   = rdata;
    auto_resend_enable = control[`CANSR_BIT_RETRY];
    status_irq = irq;
  end

endmodule : cansr_status
`default_nettype wire

// file: rtl/cansr_defines.svh
// Register offsets, field positions, reset values and limits for the CAN status and retry block.
// Function
// - Software bit turns automatic resending of errored messages on or off.
// - Reading main status register clears a pending status interrupt.
// - Main status has a flag set while controller is bus-off.
// - Error-warning flag set once either error counter reaches at least 96.
// - Main status has a flag showing the error-passive state.
// - Receive-ok flag set on any successful reception, filter match or not.
// - Transmit-ok flag set on every successful transmission.
// - Main status holds a 3-bit last-error-code field including no error.
// - Stuffing error and fixed-format form error have distinct codes.
// - Missing acknowledgement of own frame has a distinct code.
// - Recessive driven but dominant seen reports a bit-one error code.
// - Dominant driven but recessive seen reports a bit-zero error code.
// - Checksum mismatch in a received frame has a distinct code.
// - Four 32-bit per-object bitmaps let software survey all objects at once.
// - Pending bit set while the object still waits to transmit.
// - Fresh-data bit set once a new message is stored and not yet read.
// - Valid bit set while object holds a valid configuration, clear when unused.
// - Exactly 32 message objects, numbered 1 to 32.
// - Overwriting unread stored data flags data-lost for that object.
`ifndef CANSR_DEFINES_SVH
`define CANSR_DEFINES_SVH

`define CANSR_OFF_STATUS     12'h000
`define CANSR_OFF_TX_PEND    12'h004
`define CANSR_OFF_FRESH      12'h008
`define CANSR_OFF_VALID      12'h00C
`define CANSR_OFF_CONTROL    12'h010
`define CANSR_OFF_LOST       12'h014
`define CANSR_OFF_ERRCNT     12'h018

`define CANSR_BIT_LEC_LSB    0
`define CANSR_BIT_TXOK       3
`define CANSR_BIT_RXOK       4
`define CANSR_BIT_EPASS      5
`define CANSR_BIT_EWARN      6
`define CANSR_BIT_BUSOFF     7
`define CANSR_BIT_STS_INT    8

`define CANSR_BIT_RETRY      0
`define CANSR_BIT_STS_IEN    1

`define CANSR_RST_CONTROL    2'h1
`define CANSR_WARN_LIMIT     8'h60
`define CANSR_PASSIVE_LIMIT  8'h80
`define CANSR_OBJECTS        32

`endif

// file: rtl/cansr_pkg.sv
// Types shared by the CAN status and retry block.
`default_nettype none
package cansr_pkg;

  // Last error code values.
  typedef enum logic [2:0] {
    CANSR_LEC_NONE     = 3'h0,
    CANSR_LEC_STUFF    = 3'h1,
    CANSR_LEC_FORM     = 3'h2,
    CANSR_LEC_NOACK    = 3'h3,
    CANSR_LEC_REC_OVR  = 3'h4,
    CANSR_LEC_DOM_LOST = 3'h5,
    CANSR_LEC_CHECKSUM = 3'h6,
    CANSR_LEC_UNUSED   = 3'h7
  } cansr_lec_t;

  // Events reported by the protocol engine: ok and error flags are one-cycle pulses, counters and bus-off are levels.
  typedef struct packed {
    logic       rx_ok;
    logic       tx_ok;
    logic       err_valid;
    cansr_lec_t err_code;
    logic [7:0] tx_err_count;
    logic [7:0] rx_err_count;
    logic       bus_off;
  } cansr_engine_t;

  // Per-object events, one bit per object.
  typedef struct packed {
    logic [31:0] tx_request;
    logic [31:0] tx_done;
    logic [31:0] rx_store;
    logic [31:0] host_read;
    logic [31:0] cfg_set;
    logic [31:0] cfg_clear;
  } cansr_obj_ev_t;

endpackage : cansr_pkg
`default_nettype wire

// file: sim/cansr_status_assertions.sv
// Concurrent checks on the register bus and status outputs of the CAN status block.
`timescale 1ns/1ps
`default_nettype none
module cansr_status_assertions (
  input wire logic                     clk,
  input wire logic                     reset,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [11:0]              s_axi_araddr,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire cansr_pkg::cansr_engine_t engine,
  input wire logic                     auto_resend_enable,
  input wire logic                     status_irq
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Reads answer one cycle after acceptance and hold until taken.
  AST_READ_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_READ_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken early");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h018
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Writes answer within two cycles and hold until taken.
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_RESEND_RESET: assert property ($fell(reset) |-> auto_resend_enable)
    else $error("resend not on after reset");
  // A quiet status read, with no pulse and no level change, leaves the interrupt low on the next cycle.
  AST_READ_CLEARS_IRQ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
    && !engine.rx_ok && !engine.tx_ok && !engine.err_valid
    && $stable({engine.tx_err_count, engine.rx_err_count, engine.bus_off}) |=> !status_irq)
    else $error("status read left interrupt pending");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (status_irq);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : cansr_status_assertions

bind cansr_status cansr_status_assertions chk_u (.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .engine, .auto_resend_enable, .status_irq);
`default_nettype wire

// file: sim/cansr_node_model.sv
// Model of the bus nodes and protocol engine that feed events to the status block.
`timescale 1ns/1ps
`default_nettype none
module cansr_node_model (
  input wire logic                    clk,
  output var cansr_pkg::cansr_engine_t engine,
  output var cansr_pkg::cansr_obj_ev_t obj_ev
);
  // Quiet bus at start.
  initial begin
    engine = '0;
    obj_ev = '0;
  end

  // One frame outcome as a single-cycle pulse; the code is scrambled afterwards as it is no longer valid.
  task automatic frame(input logic rx, input logic tx, input logic err, input cansr_pkg::cansr_lec_t code);
    @(posedge clk);
    engine.rx_ok     <= rx;
    engine.tx_ok     <= tx;
    engine.err_valid <= err;
    engine.err_code  <= code;
    @(posedge clk);
    engine.rx_ok     <= 1'b0;
    engine.tx_ok     <= 1'b0;
    engine.err_valid <= 1'b0;
    engine.err_code  <= cansr_pkg::cansr_lec_t'(~code);
  endtask : frame

  // Error counters and bus-off are levels that persist until changed.
  task automatic counters(input logic [7:0] tec, input logic [7:0] rec, input logic boff);
    @(posedge clk);
    engine.tx_err_count <= tec;
    engine.rx_err_count <= rec;
    engine.bus_off      <= boff;
  endtask : counters

  // Per-object events last one cycle.
  task automatic objects(input cansr_pkg::cansr_obj_ev_t ev);
    @(posedge clk);
    obj_ev <= ev;
    @(posedge clk);
    obj_ev <= '0;
  endtask : objects
endmodule : cansr_node_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the CAN status block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic                     auto_resend_enable, status_irq;
  logic [11:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]              s_axi_wdata, s_axi_rdata, d;
  logic [3:0]               s_axi_wstrb;
  logic [1:0]               s_axi_bresp, s_axi_rresp, r;
  cansr_pkg::cansr_engine_t engine;
  cansr_pkg::cansr_obj_ev_t obj_ev, ev;
  int                       bad_count, checked, cyc;

  cansr_status dut_u (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .engine, .obj_ev,
    .auto_resend_enable, .status_irq);
  cansr_node_model node_u (.clk, .engine, .obj_ev);

  // Free-running clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %08X expected %08X", $time, got, exp);
    end
  endtask : chk

  // Write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd(a);
    chk(d & m, exp);
  endtask : rdchk

  task automatic ob(input int f, input logic [31:0] m);
    ev = '0;
    ev[32*f +: 32] = m;
    node_u.objects(ev);
  endtask : ob

  task automatic t_codes;
    node_u.frame(1'b1, 1'b0, 1'b0, cansr_pkg::CANSR_LEC_NONE);
    rdchk(12'h000, 32'h10, 32'h18);
    node_u.frame(1'b0, 1'b1, 1'b0, cansr_pkg::CANSR_LEC_NONE);
    rdchk(12'h000, 32'h08, 32'h18);
    for (int c = 1; c < 7; c++) begin
      node_u.frame(1'b0, 1'b0, 1'b1, cansr_pkg::cansr_lec_t'(c));
      rdchk(12'h000, 32'(c), 32'h7);
      rdchk(12'h000, 32'h0, 32'h7);
    end
  endtask : t_codes

  task automatic t_levels;
    node_u.counters(8'h5F, 8'h5F, 1'b0);
    rdchk(12'h000, 32'h00, 32'hE0);
    node_u.counters(8'h00, 8'h60, 1'b0);
    rdchk(12'h000, 32'h40, 32'hE0);
    node_u.counters(8'h7F, 8'h7F, 1'b0);
    rdchk(12'h000, 32'h40, 32'hE0);
    node_u.counters(8'h80, 8'h00, 1'b0);
    rdchk(12'h000, 32'h60, 32'hE0);
    rdchk(12'h018, 32'h00008000, '1);
    node_u.counters(8'hFF, 8'h00, 1'b1);
    rdchk(12'h000, 32'hC0, 32'hE0);
    node_u.counters(8'h00, 8'h00, 1'b0);
  endtask : t_levels

  // Struct fields from the top: 5 request, 4 done, 3 store, 2 host read, 1 set, 0 clear.
  task automatic t_objects;
    ob(5, 32'h80000001);
    rdchk(12'h004, 32'h80000001, '1);
    ob(4, 32'h00000001);
    rdchk(12'h004, 32'h80000000, '1);
    ob(4, 32'h80000000);
    ob(3, 32'h2);
    rdchk(12'h008, 32'h2, '1);
    rdchk(12'h014, 32'h0, '1);
    ob(3, 32'h2);
    rdchk(12'h014, 32'h2, '1);
    ob(2, 32'h2);
    rdchk(12'h008, 32'h0, '1);
    rdchk(12'h014, 32'h0, '1);
    ob(1, 32'hFFFF0000);
    ob(0, 32'h00010000);
    rdchk(12'h00C, 32'hFFFE0000, '1);
  endtask : t_objects

  // With resend off an error drops the waiting request; with it on the request survives.
  task automatic t_retry;
    for (int k = 0; k < 2; k++) begin
      wr(12'h010, 32'(k));
      chk({31'h0, auto_resend_enable}, 32'(k));
      ob(5, 32'h4);
      node_u.frame(1'b0, 1'b0, 1'b1, cansr_pkg::CANSR_LEC_STUFF);
      rdchk(12'h004, 32'(4 * k), '1);
    end
    ob(4, 32'h4);
  endtask : t_retry

  // Earlier events leave status pending, so it is read away before the interrupt is enabled.
  task automatic t_irq;
    rd(12'h000);
    wr(12'h010, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, status_irq}, 32'h0);
    node_u.frame(1'b1, 1'b0, 1'b0, cansr_pkg::CANSR_LEC_NONE);
    repeat (3) @(posedge clk);
    chk({31'h0, status_irq}, 32'h1);
    rdchk(12'h000, 32'h110, 32'h118);
    repeat (3) @(posedge clk);
    chk({31'h0, status_irq}, 32'h0);
  endtask : t_irq

  // Unmapped read and a write to a read-only place are refused and change nothing.
  task automatic t_bus;
    rd(12'h020);
    chk({d[29:0], r}, 32'h2);
    wr(12'h004, 32'hFFFFFFFF);
    chk({30'h0, r}, 32'h2);
    rdchk(12'h004, 32'h0, '1);
  endtask : t_bus

  // A reset in mid-run drops a raised interrupt and returns control to its default.
  task automatic t_reset;
    node_u.frame(1'b1, 1'b0, 1'b0, cansr_pkg::CANSR_LEC_NONE);
    @(posedge clk);
    chk({31'h0, status_irq}, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk({31'h0, status_irq}, 32'h0);
    rdchk(12'h010, 32'h1, 32'h3);
  endtask : t_reset

  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // Reset for six cycles, then run every scenario in turn.
  initial begin
    {reset, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = {1'b1, 56'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {bad_count, checked, cyc} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdchk(12'h010, 32'h1, 32'h3);
    rdchk(12'h004, 32'h0, '1);
    t_codes();
    t_levels();
    t_objects();
    t_retry();
    t_irq();
    t_bus();
    t_reset();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
